//--- bench/eei_pin_src.sv
`timescale 1ns/100ps
module eei_pin_src (
    // far-side levels
    input wire logic [5:0] ext_level,
    // device port side
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    output logic [5:0] pin_in
);
    // a pin the device drives shows its latch, else the source level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : eei_pin_src

//--- bench/eei_top_props.sv
`timescale 1ns/100ps
module eei_top_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hmastlock,
    input wire logic [31:0] hrdata,
    // pins and requests
    input wire logic [5:0] pin_in,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] irq_req,
    input wire logic irq
);
    logic wr;
    logic rd;
    assign wr = hsel & hready & htrans[1] & hwrite;
    assign rd = hsel & hready & htrans[1] & ~hwrite;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------
    // requests rise only from a write or an edge on an input pin
    // ----------
    AST_REQ_RISE: assert property (!$past(wr, 2) |->
        (irq_req & ~$past(irq_req) & ~(($past(pin_in, 3) ^ $past(pin_in, 4))
        & ~$past(pin_oe))) == 6'h00) else $error("request rose without cause");
    AST_REQ_FALL: assert property (|($past(irq_req) & ~irq_req) |-> $past(wr, 2))
        else $error("request fell without a write");
    AST_IRQ_RISE: assert property ($rose(irq) |->
        $past(wr, 2) || ($past(pin_in, 3) != $past(pin_in, 4)))
        else $error("irq rose without cause");
    AST_RDATA_HOLD: assert property (!$past(rd) |-> $stable(hrdata))
        else $error("read data changed without a read");
    AST_LOCK_FLAGS: assert property (
        rd && hmastlock && haddr inside {32'h124, 32'h128, 32'h12c}
        |=> hrdata[7] && hrdata[3]) else $error("locked read lost flags");
    AST_LOCK_LATCH: assert property (
        rd && hmastlock && haddr == 32'h004 |=> hrdata == {26'h0, $past(pin_out)})
        else $error("locked read is not the latch");
    AST_DIR_BY_WRITE: assert property (pin_oe != $past(pin_oe) |-> $past(wr, 2))
        else $error("direction changed without a write");
    AST_LATCH_BY_WRITE: assert property (pin_out != $past(pin_out) |-> $past(wr, 2))
        else $error("latch changed without a write");
endmodule : eei_top_props

bind eei_top eei_top_props i_eei_top_props (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hmastlock(hmastlock), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_req(irq_req), .irq(irq));

//--- bench/eei_top_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module eei_top_tb_top;
    logic clk, rst, hsel, hwrite, hmastlock, hreadyout, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, hresp;
    logic [5:0] ext, pin_in, pin_out, pin_oe, irq_req;
    logic [7:0] q, v, f;
    logic [11:0] a;
    logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h124, 12'h128,
        12'h12c, 12'hffc};
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    eei_top i_eei_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hmastlock(hmastlock), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req), .irq(irq));
    eei_pin_src i_eei_pin_src (.ext_level(ext), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ----------
    // bus tasks
    // ----------
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [7:0] d,
        input logic lk);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        hmastlock <= lk;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hmastlock <= 1'b0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata[7:0];
    endtask : xfer
    task automatic wr(input logic [11:0] ad, input logic [7:0] d);
        xfer(1'b1, ad, d, 1'b0);
    endtask : wr
    task automatic rc(input logic [11:0] ad, input logic [7:0] e, input logic lk);
        xfer(1'b0, ad, 8'h00, lk);
        `CHK(q, e)
        `CHK(hresp, 2'h0)
    endtask : rc
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // ----------
    // tests
    // ----------
    initial begin
        rst = 1'b1;
        {hsel, hwrite, hmastlock, htrans, haddr, hwdata, ext} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) rc(ra[i], 8'h00, 1'b0);
        for (int p = 0; p < 6; p++) begin
            a = 12'h124 + 12'(4 * (p / 2));
            f = 8'h08 << (4 * (p % 2));
            for (int s = 0; s < 4; s++) begin
                v = 8'(((s << 1) | (s != 1)) << (4 * (p % 2)));
                wr(a, v & 8'hee);
                wr(a, v);
                ext[p] <= 1'b1;
                wt(5);
                rc(a, v | (s[0] ? f : 8'h00), 1'b0);
                `CHK(irq_req[p], (s == 3))
                wr(a, v);
                ext[p] <= 1'b0;
                wt(5);
                rc(a, v | (s[1] ? f : 8'h00), 1'b0);
                wr(a, v);
            end
        end
        wr(12'h124, 8'h03);
        ext[0] <= 1'b1;
        wt(5);
        wr(12'h124, 8'h8b);
        rc(12'h124, 8'h0b, 1'b0);
        rc(12'h124, 8'h8b, 1'b1);
        rc(12'h124, 8'h0b, 1'b0);
        rc(12'h004, 8'h01, 1'b0);
        wr(12'h004, 8'h2a);
        rc(12'h004, 8'h01, 1'b0);
        rc(12'h004, 8'h2a, 1'b1);
        // output pin edges are ignored
        wr(12'h128, 8'h03);
        wr(12'h000, 8'h04);
        wr(12'h004, 8'h04);
        wt(5);
        rc(12'h128, 8'h03, 1'b0);
        `CHK(pin_oe, 6'h04)
        `CHK(pin_out, 6'h04)
        wr(12'h000, 8'h00);
        // status, mask and irq
        wr(12'h008, 8'h3f);
        rc(12'h008, 8'h00, 1'b0);
        ext[0] <= 1'b0;
        wt(2);
        ext[0] <= 1'b1;
        wt(5);
        rc(12'h008, 8'h01, 1'b0);
        `CHK(irq, 1'b0)
        wr(12'h00c, 8'h01);
        rc(12'h00c, 8'h01, 1'b0);
        `CHK(irq, 1'b1)
        wr(12'h008, 8'h01);
        rc(12'h008, 8'h00, 1'b0);
        `CHK(irq, 1'b0)
        stop_test();
    end
endmodule : eei_top_tb_top

//--- core/eei_edge_unit.sv
`timescale 1ns/100ps

module eei_edge_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control register access
    input wire logic ctrl_we,
    input wire logic [7:0] ctrl_wdata,
    output logic [7:0] ctrl,
    // pins, already synchronised
    input wire logic [1:0] pin_level,
    input wire logic [1:0] pin_is_input,
    // results
    output logic [1:0] edge_event,
    output logic [1:0] irq_req
);

    // ----------------------------------------------------------------
    // edge match
    // ----------------------------------------------------------------
    function automatic logic edge_match(input logic [1:0] sel, input logic rise,
                                        input logic fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            eei_pkg::SEL_NONE: hit = 1'b0;
            eei_pkg::SEL_RISE: hit = rise;
            eei_pkg::SEL_FALL: hit = fall;
            eei_pkg::SEL_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_match

    logic [7:0] cfg;
    logic [1:0] prev_level;
    logic [1:0] flag;

    // ----------------------------------------------------------------
    // select and enable fields
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= eei_pkg::CTRL_RESET;
        end else if (ctrl_we) begin
            cfg <= ctrl_wdata & ~eei_pkg::FLAG_MASK;
        end
    end

    // previous sample tracked always, so arming never fakes an edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_level <= 2'h0;
        end else begin
            prev_level <= pin_level;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < eei_pkg::CH_PER_UNIT; ch++) begin : g_ch
            localparam int BASE = ch * eei_pkg::CH_STRIDE;
            logic [1:0] sel;
            logic rise;
            logic fall;
            assign sel = cfg[BASE + eei_pkg::SEL_OFS +: 2];
            assign rise = pin_level[ch] & ~prev_level[ch];
            assign fall = ~pin_level[ch] & prev_level[ch];
            assign edge_event[ch] = pin_is_input[ch] & edge_match(sel, rise, fall);

            // set wins over a clearing write in the same cycle
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag[ch] <= 1'b0;
                end else if (edge_event[ch]) begin
                    flag[ch] <= 1'b1;
                end else if (ctrl_we && !ctrl_wdata[BASE + eei_pkg::FLAG_OFS]) begin
                    flag[ch] <= 1'b0;
                end
            end

            assign irq_req[ch] = flag[ch] & cfg[BASE + eei_pkg::EN_OFS];
        end
    endgenerate

    assign ctrl = cfg | {flag[1], 3'h0, flag[0], 3'h0};

endmodule : eei_edge_unit

//--- core/eei_pkg.sv
package eei_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NUM_UNITS = 3;
    localparam int CH_PER_UNIT = 2;
    localparam int NUM_PINS = NUM_UNITS * CH_PER_UNIT;

    // ----------------------------------------------------------------
    // control register layout, channel n fields at n * CH_STRIDE
    // ----------------------------------------------------------------
    localparam int CH_STRIDE = 4;
    localparam int EN_OFS = 0;
    localparam int SEL_OFS = 1;
    localparam int FLAG_OFS = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FLAG_MASK = 8'h88;

    // edge select encodings
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_RISE = 2'h1;
    localparam logic [1:0] SEL_FALL = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;

    // ----------------------------------------------------------------
    // register map, byte addresses on the bus
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [7:0] CTRL_UNIT1_INDEX = 8'h49;
    localparam logic [7:0] CTRL_UNIT2_INDEX = 8'h4a;
    localparam logic [7:0] CTRL_UNIT3_INDEX = 8'h4b;
    localparam logic [11:0] CTRL_UNIT1_ADDR = {2'h0, CTRL_UNIT1_INDEX, 2'h0};
    localparam logic [11:0] CTRL_UNIT2_ADDR = {2'h0, CTRL_UNIT2_INDEX, 2'h0};
    localparam logic [11:0] CTRL_UNIT3_ADDR = {2'h0, CTRL_UNIT3_INDEX, 2'h0};
    localparam logic [11:0] PORT_DIR_ADDR = 12'h000;
    localparam logic [11:0] PORT_DATA_ADDR = 12'h004;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h008;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h00c;

    localparam logic [5:0] PORT_DIR_RESET = 6'h00;
    localparam logic [5:0] PORT_DATA_RESET = 6'h00;
    localparam logic [5:0] IRQ_MASK_RESET = 6'h00;

    // decoded register selector
    typedef enum logic [2:0] {
        EEI_REG_NONE = 3'h0,
        EEI_REG_DIR = 3'h1,
        EEI_REG_DATA = 3'h2,
        EEI_REG_STATUS = 3'h3,
        EEI_REG_MASK = 3'h4,
        EEI_REG_CTRL1 = 3'h5,
        EEI_REG_CTRL2 = 3'h6,
        EEI_REG_CTRL3 = 3'h7
    } eei_reg_type;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage : eei_pkg

//--- core/eei_top.sv
`timescale 1ns/100ps

// Function
// - pin triggers only when input and armed
// - port read live pin on inputs, latch on outputs; locked read latch
// - channel 1 flag bit 7 set on edge
// - channel 0 flag bit 3 set on edge
// - select 00 none, 01 rise, 10 fall, 11 both
// - request equals flag and enable
// - writing zero clears flag, one keeps
// - locked read returns flag bits as one
// - pin readable whatever the enable bit
// - three identical two-channel units
module eei_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hmastlock,
    output logic hreadyout,
    output logic [1:0] hresp,
    output logic [31:0] hrdata,
    // shared pins, index 0..5 are edge_pin_a..edge_pin_f
    input wire logic [5:0] pin_in,
    output logic [5:0] pin_out,
    output logic [5:0] pin_oe,
    // interrupt requests
    output logic [5:0] irq_req,
    output logic irq
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic eei_pkg::eei_reg_type decode(input logic [31:0] addr);
        eei_pkg::eei_reg_type r;
        r = eei_pkg::EEI_REG_NONE;
        if (addr[31:eei_pkg::ADDR_W] == 20'h00000) begin
            case (addr[11:0])
                eei_pkg::PORT_DIR_ADDR: r = eei_pkg::EEI_REG_DIR;
                eei_pkg::PORT_DATA_ADDR: r = eei_pkg::EEI_REG_DATA;
                eei_pkg::IRQ_STATUS_ADDR: r = eei_pkg::EEI_REG_STATUS;
                eei_pkg::IRQ_MASK_ADDR: r = eei_pkg::EEI_REG_MASK;
                eei_pkg::CTRL_UNIT1_ADDR: r = eei_pkg::EEI_REG_CTRL1;
                eei_pkg::CTRL_UNIT2_ADDR: r = eei_pkg::EEI_REG_CTRL2;
                eei_pkg::CTRL_UNIT3_ADDR: r = eei_pkg::EEI_REG_CTRL3;
                default: r = eei_pkg::EEI_REG_NONE;
            endcase
        end
        return r;
    endfunction : decode

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // edges held off until the previous-sample flops hold a real pin level,
    // so a pin idling high does not fake a rising edge after reset
    logic [2:0] sync_fill;
    logic sync_primed;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_fill <= 3'h0;
        end else begin
            sync_fill <= {sync_fill[1:0], 1'b1};
        end
    end

    assign sync_primed = sync_fill[2];

    // ----------------------------------------------------------------
    // bus phases
    // ----------------------------------------------------------------
    logic addr_valid;
    logic dp_write;
    eei_pkg::eei_reg_type dp_reg;
    eei_pkg::eei_reg_type rd_reg;
    logic [7:0] wbyte;

    assign addr_valid = hsel & hready & htrans[1];
    assign rd_reg = decode(haddr);
    assign wbyte = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp = eei_pkg::HRESP_OKAY;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dp_write <= 1'b0;
            dp_reg <= eei_pkg::EEI_REG_NONE;
        end else begin
            dp_write <= addr_valid & hwrite;
            dp_reg <= rd_reg;
        end
    end

    // ----------------------------------------------------------------
    // port direction and data latch
    // ----------------------------------------------------------------
    logic [5:0] port_dir;
    logic [5:0] port_latch;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_dir <= eei_pkg::PORT_DIR_RESET;
        end else if (dp_write && dp_reg == eei_pkg::EEI_REG_DIR) begin
            port_dir <= wbyte[5:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_latch <= eei_pkg::PORT_DATA_RESET;
        end else if (dp_write && dp_reg == eei_pkg::EEI_REG_DATA) begin
            port_latch <= wbyte[5:0];
        end
    end

    assign pin_out = port_latch;
    assign pin_oe = port_dir;

    // ----------------------------------------------------------------
    // edge units
    // ----------------------------------------------------------------
    logic [7:0] ctrl [eei_pkg::NUM_UNITS];
    logic [5:0] edge_event;

    genvar u;
    generate
        for (u = 0; u < eei_pkg::NUM_UNITS; u++) begin : g_unit
            logic we;
            assign we = dp_write && (dp_reg == eei_pkg::eei_reg_type'(3'(5 + u)));
            eei_edge_unit u_unit (
                .clk(clk),
                .rst(rst),
                .ctrl_we(we),
                .ctrl_wdata(wbyte),
                .ctrl(ctrl[u]),
                .pin_level(pin_sync[2 * u +: 2]),
                .pin_is_input(~port_dir[2 * u +: 2] & {2{sync_primed}}),
                .edge_event(edge_event[2 * u +: 2]),
                .irq_req(irq_req[2 * u +: 2])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // summary interrupt
    // ----------------------------------------------------------------
    logic [5:0] irq_status;
    logic [5:0] irq_mask;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status <= 6'h00;
        end else if (dp_write && dp_reg == eei_pkg::EEI_REG_STATUS) begin
            irq_status <= (irq_status & ~wbyte[5:0]) | edge_event;
        end else begin
            irq_status <= irq_status | edge_event;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_mask <= eei_pkg::IRQ_MASK_RESET;
        end else if (dp_write && dp_reg == eei_pkg::EEI_REG_MASK) begin
            irq_mask <= wbyte[5:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // read data, locked reads act as read-modify-write
    // ----------------------------------------------------------------
    logic [7:0] next_rbyte;
    logic [7:0] flag_force;
    logic [5:0] port_view;

    assign flag_force = hmastlock ? eei_pkg::FLAG_MASK : 8'h00;
    // live pin for inputs regardless of enable bits; latch otherwise
    assign port_view = hmastlock ? port_latch
                                 : ((pin_sync & ~port_dir) | (port_latch & port_dir));

    always_comb begin
        next_rbyte = 8'h00;
        case (rd_reg)
            eei_pkg::EEI_REG_DIR: next_rbyte = {2'h0, port_dir};
            eei_pkg::EEI_REG_DATA: next_rbyte = {2'h0, port_view};
            eei_pkg::EEI_REG_STATUS: next_rbyte = {2'h0, irq_status};
            eei_pkg::EEI_REG_MASK: next_rbyte = {2'h0, irq_mask};
            eei_pkg::EEI_REG_CTRL1: next_rbyte = ctrl[0] | flag_force;
            eei_pkg::EEI_REG_CTRL2: next_rbyte = ctrl[1] | flag_force;
            eei_pkg::EEI_REG_CTRL3: next_rbyte = ctrl[2] | flag_force;
            default: next_rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (addr_valid && !hwrite) begin
            hrdata <= {24'h000000, next_rbyte};
        end
    end

endmodule : eei_top
